// *** verilog/gcrbf_consts.vh ***
// Purpose: shared constants of the group-coded block framer
// Assumes: 50 MHz clock, one nine-bit character per tape character time
// Notes: subgroup patterns are five serial bits per track, sent msb first
`ifndef GCRBF_CONSTS_VH
`define GCRBF_CONSTS_VH
`define GCRBF_CLK_MHZ 50
`define GCRBF_PAT_TERM_LEAD 5'h15
`define GCRBF_PAT_TERM_TRAIL 5'h14
`define GCRBF_PAT_SECOND_LEAD 5'h0f
`define GCRBF_PAT_SECOND_TRAIL 5'h1e
`define GCRBF_PAT_SYNC 5'h1f
`define GCRBF_PAT_MARK1 5'h07
`define GCRBF_PAT_MARK2 5'h1c
`define GCRBF_PAT_ENDMARK 5'h1f
`define GCRBF_SYNC_SUBGROUPS 14
`define GCRBF_PRE_SUBGROUPS 16
`define GCRBF_MAX_GROUPS 158
`define GCRBF_RESYNC_SYNCS 2
`define GCRBF_GROUP_DATA 7
`define GCRBF_RESID_MAX 6
`define GCRBF_CRC_COPIES 5
`define GCRBF_TM_MIN 250
`define GCRBF_TM_MAX 400
`define GCRBF_TM_LEN 300
`define GCRBF_TM_DETECT 16
`define GCRBF_GAP_MILS 300
`define GCRBF_TMGAP_MILS 3300
`define GCRBF_LONGGAP_FEET 15
`define GCRBF_ZONE1 9'h049
`define GCRBF_ZONE2 9'h092
`define GCRBF_ZONE3 9'h124
`define GCRBF_IDBURST 9'h020
`define GCRBF_RCNT_DATA_LSB 0
`define GCRBF_RCNT_REC_LSB 3
`endif

// *** verilog/gcrbf_xlate.v ***
// Purpose: four-to-five bit track code translation, both ways
// Assumes: pure combinational lookup
// Notes: an unknown stored code decodes as zero and raises bad
`timescale 1ns/1ns
module gcrbf_xlate
(
  input wire [3:0] dataIn,
  output reg [4:0] codeOut,
  input wire [4:0] codeIn,
  output reg [3:0] dataOut,
  output reg bad
);
  // encode table
  always @*
  begin
    case (dataIn)
      4'h0: codeOut = 5'h19;
      4'h1: codeOut = 5'h1b;
      4'h2: codeOut = 5'h12;
      4'h3: codeOut = 5'h13;
      4'h4: codeOut = 5'h1d;
      4'h5: codeOut = 5'h15;
      4'h6: codeOut = 5'h16;
      4'h7: codeOut = 5'h17;
      4'h8: codeOut = 5'h1a;
      4'h9: codeOut = 5'h09;
      4'ha: codeOut = 5'h0a;
      4'hb: codeOut = 5'h0b;
      4'hc: codeOut = 5'h1e;
      4'hd: codeOut = 5'h0d;
      4'he: codeOut = 5'h0e;
      default: codeOut = 5'h0f;
    endcase
  end
  // inverse table
  always @*
  begin
    bad = 1'b0;
    case (codeIn)
      5'h19: dataOut = 4'h0;
      5'h1b: dataOut = 4'h1;
      5'h12: dataOut = 4'h2;
      5'h13: dataOut = 4'h3;
      5'h1d: dataOut = 4'h4;
      5'h15: dataOut = 4'h5;
      5'h16: dataOut = 4'h6;
      5'h17: dataOut = 4'h7;
      5'h1a: dataOut = 4'h8;
      5'h09: dataOut = 4'h9;
      5'h0a: dataOut = 4'ha;
      5'h0b: dataOut = 4'hb;
      5'h1e: dataOut = 4'hc;
      5'h0d: dataOut = 4'hd;
      5'h0e: dataOut = 4'he;
      5'h0f: dataOut = 4'hf;
      default:
      begin
        dataOut = 4'h0;
        bad = 1'b1;
      end
    endcase
  end
endmodule // gcrbf_xlate

// *** verilog/gcrbf_skid.v ***
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: one clock, asynchronous active-high reset
// Notes: inReady is registered-free full test, so a stall loses nothing
`timescale 1ns/1ns
module gcrbf_skid
#(
  parameter WIDTH = 9
)
(
  input wire clk,
  input wire rst,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] slot0;
  reg [WIDTH-1:0] slot1;
  reg [1:0] count;
  wire push;
  wire pop;
  assign inReady = (count != 2'd2);
  assign outValid = (count != 2'd0);
  assign outData = slot0;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  // slot0 is the head; slot1 holds the second word
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      slot0 <= {WIDTH{1'b0}};
      slot1 <= {WIDTH{1'b0}};
      count <= 2'd0;
    end
    else
    begin
      if (pop)
      begin
        slot0 <= (count == 2'd2) ? slot1 : inData;
        if (count == 2'd2 && push)
          slot1 <= inData;
      end
      else if (push)
      begin
        if (count == 2'd0)
          slot0 <= inData;
        else
          slot1 <= inData;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // gcrbf_skid

// *** verilog/gcrbf_framer.v ***
// Purpose: group-coded nine-track block framer and deframer
// Assumes: one nine-bit tape character per accepted stream beat
// Notes: ECC and CRC characters come in from outside; polynomials not here
// Functional notes
// - a write block with zero data bytes is refused
// - a read gap reaching fifteen feet halts motion and sets reject (counted only while busy is low)
// - tape mark is all ones in zones one and two, zone three blank
// - read tape mark seen after enough contiguous zone patterns
// - normal gap 0.3 inch, gap before tape mark 3.3 inch
// - identification burst uses track six only, others erased
// - preamble is sixteen five-byte control subgroups
// - terminator is 10101 leading, 1010 then reset trailing
// - second control subgroup is 01111 leading, 11110 trailing
// - fourteen all-ones sync subgroups follow the second subgroup
// - start marker is 00111; backward read sees end marker as start
// - end marker is 11100; backward read sees start marker as end
// - data group is seven data bytes then ECC byte eight
// - each track four bits become five stored bits, reversed on read (write path stores characters untranslated)
// - at most 158 groups, then resync if more than six bytes remain
// - an all-ones end mark announces the residual group
// - residual group is data padded to six, CRC byte, then ECC
// - even group count adds a zero pad byte first in CRC group
// - CRC group holds five CRC copies after the pad, six with no pad, then residual count, then ECC
// - residual count keeps record count high, data count low bits
// - postamble mirrors preamble and serves backward sync
// - end of tape is only reported, never blocks operations
// - translation uses the fixed sixteen-entry map
// - resync is end marker, two syncs, start marker
`timescale 1ns/1ns
`include "gcrbf_consts.vh"
module gcrbf_framer
#(
  parameter GAP_CHARS = 1875,
  parameter TMGAP_CHARS = 20625,
  parameter LONGGAP_CYCLES = 32'd50000000
)
(
  input wire clk,
  input wire rst,
  input wire startWrite,
  input wire writeMark,
  input wire writeIdBurst,
  input wire [15:0] byteCount,
  input wire [4:0] recordCount,
  output wire writeRefused,
  input wire inValid,
  output wire inReady,
  input wire [8:0] inByte,
  input wire [7:0] eccByte,
  input wire [7:0] crcByte,
  input wire [7:0] auxCrcByte,
  output wire tapeValid,
  input wire tapeReady,
  output wire [8:0] tapeChar,
  output reg gapActive,
  output reg busy,
  input wire readBackward,
  input wire readValid,
  input wire [8:0] readChar,
  input wire readGapPin,
  input wire endOfTapePin,
  output reg readDataValid,
  output reg [3:0] readNibble,
  output reg [8:0] readTrackMask,
  output reg readMark1,
  output reg readMark2,
  output reg tapeMarkSeen,
  output reg rejectStatus,
  output reg haltMotion,
  output reg endOfTapeStatus
);
  localparam IDLE = 4'd0, GAP = 4'd1, PRE = 4'd2, DATA = 4'd3, RESYNC = 4'd4;
  localparam ENDM = 4'd5, RESID = 4'd6, CRCG = 4'd7, POST = 4'd8, TMARK = 4'd9;
  localparam IDB = 4'd10, TRAIL = 4'd11;
  reg [3:0] state;
  reg [3:0] after;
  reg [15:0] remain;
  reg [15:0] cnt;
  reg [7:0] groups;
  reg [2:0] pos;
  reg evenGroups;
  reg [8:0] word;
  reg wordValid;
  wire bufReady;
  wire skidReady;
  wire [15:0] residMod;
  // track patterns: all nine tracks carry the same serial bit
  function [8:0] pbit;
    input [4:0] pat;
    input [2:0] k;
    begin
      pbit = {9{pat[3'd4 - k]}};
    end
  endfunction
  // odd parity character, parity in bit eight
  function [8:0] oddp;
    input [7:0] b;
    begin
      oddp = {~^b, b};
    end
  endfunction
  assign writeRefused = startWrite && !busy && (byteCount == 16'h0000);
  assign inReady = (state == DATA || state == RESID) && bufReady && remain != 16'h0000 &&
    pos < (state == DATA ? 3'd7 : 3'd6);
  assign bufReady = !wordValid || skidReady; // held word leaves only when buffer takes it
  assign residMod = byteCount % 16'd7;
  // emitted characters pass the two-entry buffer so a drive stall loses nothing
  gcrbf_skid #(.WIDTH(9)) uBuf
  (
    .clk(clk),
    .rst(rst),
    .inValid(wordValid),
    .inReady(skidReady),
    .inData(word),
    .outValid(tapeValid),
    .outReady(tapeReady),
    .outData(tapeChar)
  );
  // subgroup pattern for preamble position cnt (0..16 incl. mark 1)
  function [4:0] prePat;
    input [4:0] sg;
    begin
      if (sg == 5'd0)
        prePat = `GCRBF_PAT_TERM_LEAD;
      else if (sg == 5'd1)
        prePat = `GCRBF_PAT_SECOND_LEAD;
      else if (sg < 5'd16)
        prePat = `GCRBF_PAT_SYNC;
      else
        prePat = `GCRBF_PAT_MARK1;
    end
  endfunction
  // postamble is the preamble backward: mark 2, syncs, second, terminator
  function [4:0] postPat;
    input [4:0] sg;
    begin
      if (sg == 5'd0)
        postPat = `GCRBF_PAT_MARK2;
      else if (sg < 5'd15)
        postPat = `GCRBF_PAT_SYNC;
      else if (sg == 5'd15)
        postPat = `GCRBF_PAT_SECOND_TRAIL;
      else
        postPat = `GCRBF_PAT_TERM_TRAIL;
    end
  endfunction
  // resync: mark 2, two syncs, mark 1
  function [4:0] rsPat;
    input [4:0] sg;
    begin
      if (sg == 5'd0)
        rsPat = `GCRBF_PAT_MARK2;
      else if (sg == 5'd3)
        rsPat = `GCRBF_PAT_MARK1;
      else
        rsPat = `GCRBF_PAT_SYNC;
    end
  endfunction
  // write sequencer; a character is produced only when the buffer has room
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= IDLE;
      after <= IDLE;
      remain <= 16'h0000;
      cnt <= 16'h0000;
      groups <= 8'h00;
      pos <= 3'd0;
      evenGroups <= 1'b1;
      word <= 9'h000;
      wordValid <= 1'b0;
      gapActive <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      if (skidReady)
        wordValid <= 1'b0;
      case (state)
        IDLE:
        begin
          gapActive <= 1'b0;
          busy <= 1'b0;
          cnt <= 16'h0000;
          if (writeIdBurst)
          begin
            state <= IDB;
            busy <= 1'b1;
          end
          else if (writeMark)
          begin
            state <= GAP;
            after <= TMARK;
            busy <= 1'b1;
          end
          else if (startWrite && byteCount != 16'h0000)
          begin
            state <= GAP;
            after <= PRE;
            remain <= byteCount;
            groups <= 8'h00;
            pos <= 3'd0;
            evenGroups <= 1'b1;
            busy <= 1'b1;
          end
        end
        GAP:
        begin
          gapActive <= 1'b1;
          cnt <= cnt + 16'h0001;
          if ((after == TMARK && cnt >= TMGAP_CHARS[15:0]) ||
            (after != TMARK && cnt >= GAP_CHARS[15:0]))
          begin
            gapActive <= 1'b0;
            cnt <= 16'h0000;
            state <= after;
          end
        end
        IDB:
        begin
          if (bufReady)
          begin
            word <= cnt[0] ? `GCRBF_IDBURST : 9'h000;
            wordValid <= 1'b1;
            cnt <= cnt + 16'h0001;
            if (cnt == `GCRBF_TM_LEN - 1)
              state <= IDLE;
          end
        end
        TMARK:
        begin
          if (bufReady)
          begin
            word <= `GCRBF_ZONE1 | `GCRBF_ZONE2;
            wordValid <= 1'b1;
            cnt <= cnt + 16'h0001;
            if (cnt == `GCRBF_TM_LEN - 1)
              state <= IDLE;
          end
        end
        PRE, POST, RESYNC, ENDM:
        begin
          if (bufReady)
          begin
            if (state == PRE)
              word <= pbit(prePat(cnt[8:4]), cnt[2:0]);
            else if (state == POST)
              word <= pbit(postPat(cnt[8:4]), cnt[2:0]);
            else if (state == RESYNC)
              word <= pbit(rsPat(cnt[8:4]), cnt[2:0]);
            else
              word <= pbit(`GCRBF_PAT_ENDMARK, cnt[2:0]);
            if (state == POST && cnt[8:4] == 5'd16 && cnt[2:0] == 3'd4)
              word <= 9'h000; // trailing terminator last character resets
            wordValid <= 1'b1;
            if (cnt[2:0] == 3'd4)
            begin
              cnt <= {cnt[15:4] + 12'h001, 4'h0};
              if (state == PRE && cnt[8:4] == 5'd16)
              begin
                state <= remain > `GCRBF_RESID_MAX ? DATA : ENDM;
                cnt <= 16'h0000;
              end
              else if (state == RESYNC && cnt[8:4] == 5'd3)
              begin
                state <= DATA;
                cnt <= 16'h0000;
              end
              else if (state == ENDM)
              begin
                state <= RESID;
                cnt <= 16'h0000;
              end
              else if (state == POST && cnt[8:4] == 5'd16)
              begin
                state <= GAP;
                after <= IDLE;
                cnt <= 16'h0000;
              end
            end
            else
              cnt <= cnt + 16'h0001;
          end
        end
        DATA, RESID:
        begin
          // byte position pos: data slots, then aux crc / ecc
          if (bufReady)
          begin
            if (pos < (state == DATA ? 3'd7 : 3'd6))
            begin
              if (inValid && remain != 16'h0000)
              begin
                word <= inByte;
                wordValid <= 1'b1;
                remain <= remain - 16'h0001;
                pos <= pos + 3'd1;
              end
              else if (state == RESID && remain == 16'h0000)
              begin
                word <= oddp(8'h00);
                wordValid <= 1'b1;
                pos <= pos + 3'd1;
              end
            end
            else if (state == RESID && pos == 3'd6)
            begin
              word <= oddp(auxCrcByte);
              wordValid <= 1'b1;
              pos <= 3'd7;
            end
            else
            begin
              word <= oddp(eccByte);
              wordValid <= 1'b1;
              pos <= 3'd0;
              if (state == RESID)
                state <= CRCG;
              else
              begin
                groups <= groups + 8'h01;
                evenGroups <= ~evenGroups;
                if (remain <= `GCRBF_RESID_MAX)
                  state <= ENDM;
                else if (groups == `GCRBF_MAX_GROUPS - 1)
                begin
                  state <= RESYNC;
                  groups <= 8'h00;
                end
              end
            end
          end
        end
        CRCG:
        begin
          if (bufReady)
          begin
            wordValid <= 1'b1;
            pos <= pos + 3'd1;
            if (pos == 3'd0)
              word <= evenGroups ? oddp(8'h00) : oddp(crcByte);
            else if (pos < 3'd6)
              word <= oddp(crcByte);
            else if (pos == 3'd6)
              word <= oddp({recordCount, residMod[2:0]});
            else
            begin
              word <= oddp(eccByte);
              state <= POST;
              cnt <= 16'h0000;
              pos <= 3'd0;
            end
          end
        end
        default:
          state <= IDLE;
      endcase
    end
  end
  // read path: per-track decode of one stored character group
  reg [4:0] trk [0:8];
  reg [2:0] rpos;
  reg [3:0] tmRun;
  reg [31:0] gapCnt;
  reg [2:0] gapSync;
  reg [2:0] eotSync;
  wire [3:0] decNib [0:8];
  wire [8:0] decBad;
  genvar t;
  generate
    for (t = 0; t < 9; t = t + 1)
    begin : gTrack
      gcrbf_xlate uXlate
      (
        .dataIn(4'h0),
        .codeOut(),
        .codeIn(trk[t]),
        .dataOut(decNib[t]),
        .bad(decBad[t])
      );
    end
  endgenerate
  integer i;
  // read deframer: marks, tape mark run, stored-code reversal
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (i = 0; i < 9; i = i + 1)
        trk[i] <= 5'h00;
      rpos <= 3'd0;
      tmRun <= 4'h0;
      readDataValid <= 1'b0;
      readNibble <= 4'h0;
      readTrackMask <= 9'h000;
      readMark1 <= 1'b0;
      readMark2 <= 1'b0;
      tapeMarkSeen <= 1'b0;
    end
    else
    begin
      readDataValid <= 1'b0;
      readMark1 <= 1'b0;
      readMark2 <= 1'b0;
      if (readValid)
      begin
        for (i = 0; i < 9; i = i + 1)
          trk[i] <= {trk[i][3:0], readChar[i]};
        rpos <= (rpos == 3'd4) ? 3'd0 : rpos + 3'd1;
        if (((readChar & `GCRBF_ZONE1) == `GCRBF_ZONE1 ||
          (readChar & `GCRBF_ZONE2) == `GCRBF_ZONE2) &&
          (readChar & `GCRBF_ZONE3) == 9'h000)
        begin
          if (tmRun != 4'hf)
            tmRun <= tmRun + 4'h1;
          if (tmRun == `GCRBF_TM_DETECT - 2)
            tapeMarkSeen <= 1'b1;
        end
        else
          tmRun <= 4'h0;
      end
      if (rpos == 3'd0 && !readValid && trk[0] != 5'h00)
      begin
        readMark1 <= readBackward ? trk[0] == `GCRBF_PAT_MARK2 :
          trk[0] == `GCRBF_PAT_MARK1;
        readMark2 <= readBackward ? trk[0] == `GCRBF_PAT_MARK1 :
          trk[0] == `GCRBF_PAT_MARK2;
        readDataValid <= decBad == 9'h000;
        readNibble <= decNib[0];
        readTrackMask <= decBad;
      end
    end
  end
  // long gap watchdog and end-of-tape report on synchronised pins
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      gapSync <= 3'b000;
      eotSync <= 3'b000;
      gapCnt <= 32'h00000000;
      rejectStatus <= 1'b0;
      haltMotion <= 1'b0;
      endOfTapeStatus <= 1'b0;
    end
    else
    begin
      gapSync <= {gapSync[1:0], readGapPin};
      eotSync <= {eotSync[1:0], endOfTapePin};
      if (eotSync[2] == eotSync[1])
        endOfTapeStatus <= eotSync[2];
      if (gapSync[2] && gapSync[1] && !busy)
      begin
        if (gapCnt != LONGGAP_CYCLES)
          gapCnt <= gapCnt + 32'h00000001;
        else
        begin
          haltMotion <= 1'b1;
          rejectStatus <= 1'b1;
        end
      end
      else
      begin
        gapCnt <= 32'h00000000;
        haltMotion <= 1'b0;
        if (startWrite || writeMark)
          rejectStatus <= 1'b0;
      end
    end
  end
endmodule // gcrbf_framer

// *** sim/gcrbf_framer_properties.sv ***
// Purpose: port checks of the block framer
// Assumes: one clock, rst async active high
// Notes: gap bound allows four cycles for pin synchronising
`timescale 1ns/1ns
module gcrbf_framer_properties
#(
  parameter LONGGAP_CYCLES = 32'd50000000
)
(
  input wire clk,
  input wire rst,
  input wire startWrite,
  input wire [15:0] byteCount,
  input wire writeRefused,
  input wire busy,
  input wire tapeValid,
  input wire tapeReady,
  input wire [8:0] tapeChar,
  input wire readGapPin,
  input wire endOfTapePin,
  input wire tapeMarkSeen,
  input wire rejectStatus,
  input wire haltMotion,
  input wire endOfTapeStatus
);
  reg [31:0] gapRun;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // length of the current unbroken read gap
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      gapRun <= 32'h0;
    else if (!readGapPin)
      gapRun <= 32'h0;
    else if (gapRun != 32'hffffffff)
      gapRun <= gapRun + 32'h1;
  end
  // write request, stall and end-of-tape shapes
  sequence sWriteGo;
    startWrite && !busy && byteCount != 16'h0000;
  endsequence
  sequence sZeroWrite;
    startWrite && !busy && byteCount == 16'h0000;
  endsequence
  sequence sStall;
    tapeValid && !tapeReady;
  endsequence
  sequence sEotHeld;
    endOfTapePin [*5];
  endsequence
  AST_ZERO_REFUSED: assert property (sZeroWrite |-> writeRefused)
    else $error("empty write not refused");
  AST_REFUSED_IDLE: assert property (sZeroWrite |=> !busy)
    else $error("empty write started");
  AST_ONLY_ZERO_REFUSED: assert property (sWriteGo |-> !writeRefused)
    else $error("valid write refused");
  AST_WRITE_STARTS: assert property (sWriteGo |=> busy)
    else $error("write not started");
  AST_CHAR_HELD: assert property (sStall |=> tapeValid && $stable(tapeChar))
    else $error("character lost in stall");
  AST_LONG_GAP_HALT: assert property (gapRun == LONGGAP_CYCLES + 4 |-> haltMotion && rejectStatus)
    else $error("long gap not halted");
  AST_HALT_REJECTS: assert property (haltMotion |-> rejectStatus)
    else $error("halt without reject");
  AST_MARK_STICKY: assert property (tapeMarkSeen |=> tapeMarkSeen)
    else $error("tape mark flag dropped");
  AST_EOT_REPORTED: assert property (sEotHeld |-> endOfTapeStatus)
    else $error("end of tape not reported");
endmodule // gcrbf_framer_properties

bind gcrbf_framer gcrbf_framer_properties #(.LONGGAP_CYCLES(LONGGAP_CYCLES))
  gcrbf_framer_properties_inst
(
  .clk(clk), .rst(rst), .startWrite(startWrite), .byteCount(byteCount),
  .writeRefused(writeRefused), .busy(busy), .tapeValid(tapeValid), .tapeReady(tapeReady),
  .tapeChar(tapeChar), .readGapPin(readGapPin), .endOfTapePin(endOfTapePin),
  .tapeMarkSeen(tapeMarkSeen), .rejectStatus(rejectStatus), .haltMotion(haltMotion),
  .endOfTapeStatus(endOfTapeStatus)
);

// *** sim/gcrbf_drive_model.sv ***
// Purpose: tape drive sink for the framer character stream
// Assumes: one character taken per accepted beat
// Notes: ready drops one cycle in three to stall the framer
`timescale 1ns/1ns
module gcrbf_drive_model
(
  input wire clk,
  input wire rst,
  input wire tapeValid,
  output logic tapeReady,
  input wire [8:0] tapeChar
);
  logic [8:0] got [$];
  logic [1:0] phase;
  // record accepted characters and pace ready
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tapeReady <= 1'b0;
      phase <= 2'h0;
    end
    else
    begin
      if (tapeValid && tapeReady)
        got.push_back(tapeChar);
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      tapeReady <= (phase != 2'h2);
    end
  end
endmodule // gcrbf_drive_model

// *** sim/gcrbf_framer_tb.sv ***
// Purpose: self-checking bench of the block framer
// Assumes: 50 MHz clock, shortened gap parameters
// Notes: expected streams built from subgroup patterns
`timescale 1ns/1ns
module gcrbf_framer_tb;
  localparam GAP = 4;
  localparam TMGAP = 8;
  logic clk = 1'b0, rst = 1'b1, startWrite = 1'b0, writeMark = 1'b0, writeIdBurst = 1'b0;
  logic inValid = 1'b0, readValid = 1'b0, readGapPin = 1'b0, endOfTapePin = 1'b0;
  logic [15:0] byteCount = 16'h0000;
  logic [4:0] recordCount = 5'h09;
  logic [8:0] inByte = 9'h000, readChar = 9'h000;
  logic [7:0] eccByte = 8'h5a, crcByte = 8'h33, auxCrcByte = 8'h0f;
  wire writeRefused, inReady, tapeValid, tapeReady, gapActive, busy;
  wire tapeMarkSeen, rejectStatus, haltMotion, endOfTapeStatus, readMark1;
  wire [8:0] tapeChar;
  logic [8:0] want [$];
  integer numErrors = 0, compares = 0, cycles = 0;
  gcrbf_framer #(.GAP_CHARS(GAP), .TMGAP_CHARS(TMGAP), .LONGGAP_CYCLES(32'd100))
    gcrbf_framer_inst
  (
    .clk(clk), .rst(rst), .startWrite(startWrite), .writeMark(writeMark),
    .writeIdBurst(writeIdBurst), .byteCount(byteCount), .recordCount(recordCount),
    .writeRefused(writeRefused), .inValid(inValid), .inReady(inReady), .inByte(inByte),
    .eccByte(eccByte), .crcByte(crcByte), .auxCrcByte(auxCrcByte), .tapeValid(tapeValid),
    .tapeReady(tapeReady), .tapeChar(tapeChar), .gapActive(gapActive), .busy(busy),
    .readBackward(1'b0), .readValid(readValid), .readChar(readChar),
    .readGapPin(readGapPin), .endOfTapePin(endOfTapePin), .readDataValid(),
    .readNibble(), .readTrackMask(), .readMark1(readMark1), .readMark2(),
    .tapeMarkSeen(tapeMarkSeen), .rejectStatus(rejectStatus), .haltMotion(haltMotion),
    .endOfTapeStatus(endOfTapeStatus)
  );
  gcrbf_drive_model drive
  (
    .clk(clk), .rst(rst), .tapeValid(tapeValid), .tapeReady(tapeReady), .tapeChar(tapeChar)
  );
  // clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      numErrors = numErrors + 1;
      testDone;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] expv);
    begin
      compares = compares + 1;
      if (seen !== expv)
      begin
        numErrors = numErrors + 1;
        $display("[ERR] %0t seen %h exp %h", $time, seen, expv);
      end
    end
  endtask
  task testDone;
    begin
      if (numErrors == 0 && compares > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  function logic [8:0] par(input logic [7:0] b);
    par = {~^b, b};
  endfunction
  // one subgroup, each track serial msb first
  task pat(input logic [4:0] p, input integer times);
    integer i, k;
    begin
      for (i = 0; i < times; i = i + 1)
        for (k = 4; k >= 0; k = k - 1)
          want.push_back(p[k] ? 9'h1ff : 9'h000);
    end
  endtask
  task waitIdle;
    begin
      do
        @(posedge clk);
      while (busy !== 1'b0);
      repeat (6) @(posedge clk);
    end
  endtask
  task gapMeasure(output integer len);
    begin
      len = 0;
      while (gapActive !== 1'b1)
        @(posedge clk);
      while (gapActive === 1'b1)
      begin
        @(posedge clk);
        len = len + 1;
      end
    end
  endtask
  task feed(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1)
      begin
        inByte <= par(8'h40 + i[7:0]);
        inValid <= 1'b1;
        do
          @(posedge clk);
        while (inReady !== 1'b1);
      end
      inValid <= 1'b0;
    end
  endtask
  task testRefuse;
    begin
      @(posedge clk);
      startWrite <= 1'b1;
      #1 check(writeRefused, 1);
      @(posedge clk);
      startWrite <= 1'b0;
      #1 check(busy, 0);
    end
  endtask
  task testBlock(input integer n, input integer end_of_tape_marker);
    integer i, g, r, len;
    begin
      g = n / 7;
      r = n % 7;
      want.delete();
      drive.got.delete();
      pat(5'h15, 1);
      pat(5'h0f, 1);
      pat(5'h1f, 14);
      pat(5'h07, 1);
      for (i = 0; i < 7 * g; i = i + 1)
      begin
        want.push_back(par(8'h40 + i[7:0]));
        if (i % 7 == 6)
          want.push_back(par(eccByte));
      end
      pat(5'h1f, 1);
      for (i = 7 * g; i < 7 * g + 6; i = i + 1)
        want.push_back(i < n ? par(8'h40 + i[7:0]) : 9'h100);
      want.push_back(par(auxCrcByte));
      want.push_back(par(eccByte));
      for (i = 0; i < 6; i = i + 1)
        want.push_back((i == 0 && g % 2 == 0) ? 9'h100 : par(crcByte));
      want.push_back(par({recordCount, r[2:0]}));
      want.push_back(par(eccByte));
      pat(5'h1c, 1);
      pat(5'h1f, 14);
      pat(5'h1e, 1);
      pat(5'h15, 1);
      want[want.size() - 1] = 9'h000;
      @(posedge clk);
      endOfTapePin <= end_of_tape_marker[0];
      byteCount <= n[15:0];
      startWrite <= 1'b1;
      @(posedge clk);
      startWrite <= 1'b0;
      fork
        feed(n);
        gapMeasure(len);
      join
      waitIdle;
      check(len, GAP);
      check(endOfTapeStatus, end_of_tape_marker);
      check(drive.got.size(), want.size());
      for (i = 0; i < want.size(); i = i + 1)
        check(drive.got[i], want[i]);
    end
  endtask
  task testCmd(input integer sel);
    integer i, len;
    begin
      drive.got.delete();
      @(posedge clk);
      writeMark <= (sel == 0);
      writeIdBurst <= (sel == 1);
      @(posedge clk);
      writeMark <= 1'b0;
      writeIdBurst <= 1'b0;
      if (sel == 0)
        gapMeasure(len);
      waitIdle;
      if (sel == 0)
        check(len, TMGAP);
      check(drive.got.size() != 0, 1);
      if (sel == 0)
        check(drive.got.size(), 300);
      for (i = 0; i < drive.got.size(); i = i + 1)
        check(drive.got[i] & (sel == 0 ? 9'h1ff : 9'h1df), sel == 0 ? 9'h0db : 9'h000);
    end
  endtask
  task testReadMark;
    integer i;
    begin
      for (i = 0; i < 24; i = i + 1)
      begin
        @(posedge clk);
        readValid <= 1'b1;
        readChar <= 9'h0db;
        if (i == 8)
          check(tapeMarkSeen, 0);
      end
      @(posedge clk);
      readValid <= 1'b0;
      readChar <= 9'h000;
      repeat (3) @(posedge clk);
      check(tapeMarkSeen, 1);
    end
  endtask
  task testRdMark;
    integer i;
    begin
      for (i = 0; i < 6; i = i + 1)
      begin
        @(posedge clk);
        readValid <= (i < 5);
        readChar <= {9{i > 1}};
      end
      repeat (2) @(posedge clk);
      check(readMark1, 1);
    end
  endtask
  task testLongGap;
    begin
      @(posedge clk);
      readGapPin <= 1'b1;
      repeat (50) @(posedge clk);
      check(haltMotion, 0);
      repeat (60) @(posedge clk);
      check(haltMotion, 1);
      check(rejectStatus, 1);
      readGapPin <= 1'b0;
    end
  endtask
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    testRefuse;
    testBlock(3, 0);
    testBlock(10, 1);
    testCmd(0);
    testCmd(1);
    testRdMark;
    testReadMark;
    testLongGap;
    testDone;
  end
endmodule // gcrbf_framer_tb
